// *** core/ebl_blkmem.sv ***
// Per-block lock and blank table with registered read ports.
module ebl_blkmem
  import ebl_pkg::*;
#(
  parameter int NBLK = 16,
  parameter int AW   = 4
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          lk_we_i,     // Lock state write.
  input  wire logic          lk_guard_i,  // Skip the write if the block is locked down.
  input  wire ebl_lk_s       lk_wd_i,
  input  wire logic          bl_we_i,     // Blank flag write.
  input  wire logic          bl_wd_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [AW-1:0] rd_a_addr_i,
  input  wire logic [AW-1:0] rd_b_addr_i,
  output ebl_lk_s            rd_a_o,
  output ebl_lk_s            rd_b_o,
  output logic               rd_b_bl_o
);

  ebl_lk_s          lk_q [NBLK];  // Volatile lock bits.
  logic [NBLK-1:0]  bl_q;         // Blank flag, array contents survive reset.

  // ****************************************************************
  // Storage, one entry per block
  // ****************************************************************
  for (genvar g = 0; g < NBLK; g++) begin : g_ent
    // Lock bits come up locked and not locked down after every reset.
    // A lock-down mark, once set, holds until reset whatever lock command follows.
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        lk_q[g] <= '{ldn: 1'b0, lck: 1'b1};
      end else if (lk_we_i && wr_addr_i == AW'(g) && !(lk_guard_i && lk_q[g].ldn)) begin
        lk_q[g] <= '{ldn: lk_wd_i.ldn || lk_q[g].ldn, lck: lk_wd_i.lck};
      end
    end

    // The blank flag models the array, which a reset does not touch.
    always_ff @(posedge clk_i) begin
      if (bl_we_i && wr_addr_i == AW'(g)) begin
        bl_q[g] <= bl_wd_i;
      end
    end
  end

  // ****************************************************************
  // Registered read ports
  // ****************************************************************
  // Both ports answer one cycle after the address is presented.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_a_o    <= '0;
      rd_b_o    <= '0;
      rd_b_bl_o <= 1'b0;
    end else begin
      rd_a_o    <= lk_q[rd_a_addr_i];
      rd_b_o    <= lk_q[rd_b_addr_i];
      rd_b_bl_o <= bl_q[rd_b_addr_i];
    end
  end

endmodule : ebl_blkmem

// *** core/ebl_ctrl.sv ***
// Erase, blank check, erase suspend and block lock command control.
module ebl_ctrl
  import ebl_pkg::*;
#(
  parameter int NBLK         = 16,
  parameter int AW           = 4,
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int BLANK_CYCLES = BLANK_CYC
) (
  input  wire logic          REF_CLK_I,
  input  wire logic          RST_I,          // Reset and power-down.
  input  wire logic          CMD_WE_I,       // One-cycle command write strobe.
  input  wire ebl_cmd_s      CMD_I,
  input  wire logic [AW-1:0] CMD_BLK_I,      // Block addressed by the command.
  input  wire logic [AW-1:0] RD_BLK_I,       // Block addressed by reads.
  input  wire logic [15:0]   ARRAY_DATA_I,   // Array word from the cell core.
  input  wire logic          CE_N_I,
  input  wire logic          WP_N_I,
  input  wire logic          VPP_LOW_I,      // Supply at or below program_supply_lockout.
  input  wire logic          VERIFY_FAIL_I,  // Erase verify failure from the core.
  input  wire logic          PGM_BUSY_I,     // Program engine running.
  input  wire logic          PGM_SUSP_I,     // Program engine suspended.
  output logic [15:0]        RD_DATA_O,
  output logic [7:0]         STATUS_O,
  output logic [15:0]        RCR_O,
  output logic               STANDBY_O,
  output logic               ERASING_O,
  output logic               PGM_REQ_O,      // Program command handed to the engine.
  output logic               PGM_SUSP_REQ_O  // Program suspend handed to the engine.
);

  // ****************************************************************
  // State
  // ****************************************************************
  ebl_state_e       st_r, st_nxt;        // Operation sequencer.
  ebl_setup_e       su_r, su_nxt;        // Pending first cycle of a pair.
  ebl_rmode_e       rm_r, rm_nxt;        // What a read returns.
  logic [CNT_W-1:0] cnt_r, cnt_nxt;      // Operation progress.
  logic [AW-1:0]    blk_r;               // Block under erase or scan.
  logic             sreq_r;              // Suspend requested, not yet reached.
  logic             rpend_r;             // Resume taken, waiting on program.
  logic             efail_r, pfail_r, vpp_r, lab_r;  // Sticky error bits.
  ebl_status_s      stat_r, stat_nxt;    // Registered status word.
  logic [15:0]      rcr_r;
  logic [15:0]      rd_r;
  ebl_lk_s          mem_a, mem_b;
  logic             mem_b_bl;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wire [7:0] code    = CMD_I.code;
  wire       we      = CMD_WE_I;
  wire       pend    = su_r != SU_NONE;
  wire       idle    = st_r == ST_IDLE;
  wire       susp    = st_r == ST_ESUSP;
  // Anything but the idle state and a suspend with no resume pending blocks new commands except an erase suspend.
  wire       running = !(idle || susp) || rpend_r;
  wire       first   = we && !pend && !running;
  wire       second  = we && pend;
  wire       wp_on   = !WP_N_I;

  wire c_lock_su  = first && code == CMD_LOCK_SU;
  wire c_erase_su = first && idle && code == CMD_ERASE_SU;
  wire c_blank_su = first && idle && code == CMD_BLANK_SU;
  wire lk_code    = code == CMD_LOCK || code == CMD_UNLOCK || code == CMD_LOCKDN;
  wire c_lk_any   = second && su_r == SU_LOCK && lk_code;
  // Supply level plays no part in lock commands; a parked program freezes the table.
  wire c_lockop   = c_lk_any && !PGM_SUSP_I;
  wire c_rcr      = second && su_r == SU_LOCK && code == CMD_RCR_SET;
  wire c_ers_go   = second && su_r == SU_ERASE && code == CMD_CONFIRM;
  wire c_blk_go   = second && su_r == SU_BLANK && code == CMD_CONFIRM;
  wire seq_err    = second && !(c_lk_any || c_rcr || c_ers_go || c_blk_go);
  // Blank check never accepts a suspend.
  wire c_susp     = we && !pend && st_r == ST_ERASE && code == CMD_SUSPEND;
  wire c_resume   = first && susp && code == CMD_RESUME;
  wire c_clr      = first && code == CMD_CLR_STAT;
  wire pgm_code   = code == CMD_PGM_W || code == CMD_PGM_B;
  wire same_blk   = susp && CMD_BLK_I == blk_r;
  wire c_pgm      = first && pgm_code && !same_blk;
  wire c_pgm_bad  = first && pgm_code && same_blk;
  wire c_psusp    = first && code == CMD_SUSPEND;
  wire c_rd_arr   = first && code == CMD_RD_ARR;
  wire c_rd_st    = first && code == CMD_RD_STAT;
  wire c_rd_id    = first && (code == CMD_RD_ID || code == CMD_RD_QRY);

  // Lock write data: lock-down also locks, unlock clears only the lock bit.
  // The table ORs in an existing lock-down mark, so it survives until reset.
  wire ebl_lk_s lk_wd = {code == CMD_LOCKDN, code != CMD_UNLOCK};
  // Under write-protect a locked-down block refuses every lock command.
  wire lk_guard   = wp_on;

  // A block is protected while locked or locked down under write-protect.
  wire prot       = mem_b.lck || (mem_b.ldn && wp_on);
  wire at_stop    = cnt_r[STOP_LOG2-1:0] == '0;
  wire ers_end    = cnt_r == CNT_W'(ERASE_CYCLES - 1);
  wire blk_end    = cnt_r == CNT_W'(BLANK_CYCLES - 1);
  wire ers_done   = st_r == ST_ERASE && !VPP_LOW_I && ers_end;
  wire ers_halt   = st_r == ST_ERASE && VPP_LOW_I;
  wire chk_vpp    = st_r == ST_ECHK && VPP_LOW_I;
  wire chk_lock   = st_r == ST_ECHK && !VPP_LOW_I && prot;
  wire blk_fail   = st_r == ST_BLANK && blk_end && !mem_b_bl;
  // A resume only takes effect once no program is running or parked.
  wire rs_go      = susp && rpend_r && !PGM_BUSY_I && !PGM_SUSP_I;

  // ****************************************************************
  // Block table
  // ****************************************************************
  // The second read port follows the confirm address, then the latched block.
  wire [AW-1:0] b_addr = (c_ers_go || c_blk_go) ? CMD_BLK_I : blk_r;
  wire [AW-1:0] w_addr = ers_done ? blk_r : CMD_BLK_I;

  ebl_blkmem #(.NBLK(NBLK), .AW(AW)) u_mem (
    .clk_i       (REF_CLK_I),
    .rst_i       (RST_I),
    .lk_we_i     (c_lockop),
    .lk_guard_i  (lk_guard),
    .lk_wd_i     (lk_wd),
    .bl_we_i     (ers_done || c_pgm),
    .bl_wd_i     (ers_done),
    .wr_addr_i   (w_addr),
    .rd_a_addr_i (RD_BLK_I),
    .rd_b_addr_i (b_addr),
    .rd_a_o      (mem_a),
    .rd_b_o      (mem_b),
    .rd_b_bl_o   (mem_b_bl)
  );

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  // Halt on low supply beats completion, completion beats a suspend.
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ST_IDLE: begin
        if (c_ers_go) begin
          st_nxt = ST_ECHK;
        end else if (c_blk_go) begin
          st_nxt  = ST_BLANK;
          cnt_nxt = '0;
        end
      end
      ST_ECHK: begin
        st_nxt  = (chk_vpp || chk_lock) ? ST_IDLE : ST_ERASE;
        cnt_nxt = '0;
      end
      ST_ERASE: begin
        if (ers_halt || ers_done) begin
          st_nxt = ST_IDLE;
        end else if ((sreq_r || c_susp) && at_stop) begin
          st_nxt = ST_ESUSP;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_ESUSP: begin
        // The erase picks up where it stopped, even if its block was relocked.
        if (rs_go) begin
          st_nxt  = ST_ERASE;
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_BLANK: begin
        if (blk_end) begin
          st_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // Pair tracking: any second cycle ends the pair.
  assign su_nxt = c_lock_su  ? SU_LOCK  :
                  c_erase_su ? SU_ERASE :
                  c_blank_su ? SU_BLANK :
                  second     ? SU_NONE  : su_r;

  // Reads return status after every operation command but a program suspend or a refused program.
  assign rm_nxt = c_rd_arr ? RM_ARRAY :
                  c_rd_id  ? RM_IDENT :
                  (c_rd_st || second || c_susp || c_resume || c_pgm || c_erase_su ||
                   c_blank_su || c_lock_su) ? RM_STATUS : rm_r;

  // Status word: the ready bit follows the sequencer and the program engine, buffer busy is held low, errors are sticky.
  always_comb begin
    stat_nxt        = '0;
    stat_nxt.rdy    = !running && !PGM_BUSY_I;
    stat_nxt.esusp  = sreq_r || (susp && !rpend_r);
    stat_nxt.psusp  = PGM_SUSP_I;
    stat_nxt.efail  = efail_r;
    stat_nxt.pfail  = pfail_r;
    stat_nxt.vpp    = vpp_r;
    stat_nxt.labort = lab_r;
    stat_nxt.bbusy  = 1'b0;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset aborts any operation; the aborted block keeps whatever it held.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r    <= ST_IDLE;
      su_r    <= SU_NONE;
      rm_r    <= RM_ARRAY;
      cnt_r   <= '0;
      blk_r   <= '0;
      sreq_r  <= 1'b0;
      rpend_r <= 1'b0;
      stat_r  <= ebl_status_s'(STATUS_RST);
      rcr_r   <= RCR_RST;
    end else begin
      st_r    <= st_nxt;
      su_r    <= su_nxt;
      rm_r    <= rm_nxt;
      cnt_r   <= cnt_nxt;
      blk_r   <= (c_ers_go || c_blk_go) ? CMD_BLK_I : blk_r;
      sreq_r  <= (sreq_r || c_susp) && st_nxt == ST_ERASE;
      rpend_r <= (rpend_r || c_resume) && !rs_go;
      stat_r  <= stat_nxt;
      rcr_r   <= c_rcr ? CMD_I.cfg : rcr_r;
    end
  end

  // Error bits: a setting event wins over a clear in the same cycle.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      efail_r <= 1'b0;
      pfail_r <= 1'b0;
      vpp_r   <= 1'b0;
      lab_r   <= 1'b0;
    end else begin
      efail_r <= (efail_r && !c_clr) || seq_err || chk_lock || blk_fail ||
                 (ers_done && VERIFY_FAIL_I);
      pfail_r <= (pfail_r && !c_clr) || seq_err || c_pgm_bad;
      vpp_r   <= (vpp_r && !c_clr) || ers_halt || chk_vpp;
      lab_r   <= (lab_r && !c_clr) || chk_lock;
    end
  end

  // Read data register; the lock bits sit in the two low bits.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rd_r <= '0;
    end else begin
      case (rm_r)
        RM_STATUS: rd_r <= {8'h00, stat_r};
        RM_IDENT:  rd_r <= {ID_PAD[15:2], mem_a.ldn, mem_a.lck};
        default:   rd_r <= ARRAY_DATA_I;
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign RD_DATA_O      = rd_r;
  assign STATUS_O       = stat_r;
  assign RCR_O          = rcr_r;
  // Standby waits for a running erase or scan; a suspended erase may sleep.
  assign STANDBY_O      = CE_N_I && !running;
  assign ERASING_O      = st_r == ST_ERASE;
  assign PGM_REQ_O      = c_pgm;
  assign PGM_SUSP_REQ_O = c_psusp;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_vpp_halt: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ers_halt |=> st_r == ST_IDLE && vpp_r) else $error("supply halt missed");
  a_lock_anyvpp: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (second && su_r == SU_LOCK && code == CMD_LOCK && !PGM_SUSP_I) |-> c_lockop)
    else $error("lock refused");
  a_erase_blank: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    ers_done |=> st_r == ST_IDLE ##1 mem_b_bl) else $error("block not blank");
  a_standby_busy: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    st_r == ST_ERASE |-> !STANDBY_O) else $error("standby during erase");
  a_status_mode: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    c_ers_go |=> rm_r == RM_STATUS ##1 RD_DATA_O[15:8] == 8'h00)
    else $error("status mode lost");
  a_rdy_busy: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (st_r == ST_ERASE)[*2] |-> !STATUS_O[7]) else $error("ready while erasing");
  a_blank_nosusp: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    st_r == ST_BLANK |=> st_r inside {ST_BLANK, ST_IDLE}) else $error("blank left");
  a_blank_fail: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    blk_fail |=> efail_r ##1 STATUS_O[5]) else $error("blank fail lost");
  a_susp_point: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(st_r == ST_ESUSP) |-> at_stop ##1 STATUS_O[7:6] == 2'b11)
    else $error("suspend point wrong");
  a_resume_wait: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (susp && PGM_BUSY_I) |=> st_r == ST_ESUSP) else $error("resumed over program");
  a_seq_err: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    seq_err |=> pfail_r && efail_r) else $error("sequence error lost");
  a_err_sticky: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    (efail_r && !c_clr) |=> efail_r) else $error("error bit dropped");

endmodule : ebl_ctrl

// *** core/ebl_pkg.sv ***
// Package of command codes, status layout, states and counts for erase and lock control.
package ebl_pkg;

  // ****************************************************************
  // Command codes taken on the write strobe
  // ****************************************************************
  localparam logic [7:0] CMD_ERASE_SU = 8'h20;  // Block erase setup.
  localparam logic [7:0] CMD_BLANK_SU = 8'hBC;  // Blank check setup.
  localparam logic [7:0] CMD_CONFIRM  = 8'hD0;  // Erase or blank check confirm.
  localparam logic [7:0] CMD_RESUME   = 8'hD0;  // Erase resume.
  localparam logic [7:0] CMD_SUSPEND  = 8'hB0;  // Erase or program suspend.
  localparam logic [7:0] CMD_CLR_STAT = 8'h50;  // Clear the sticky error bits.
  localparam logic [7:0] CMD_RD_STAT  = 8'h70;  // Read status word.
  localparam logic [7:0] CMD_RD_ARR   = 8'hFF;  // Read array.
  localparam logic [7:0] CMD_RD_ID    = 8'h90;  // Read identifier and block lock bits.
  localparam logic [7:0] CMD_RD_QRY   = 8'h98;  // Query read.
  localparam logic [7:0] CMD_LOCK_SU  = 8'h60;  // Lock setup.
  localparam logic [7:0] CMD_LOCK     = 8'h01;  // Lock block.
  localparam logic [7:0] CMD_UNLOCK   = 8'hD0;  // Unlock block.
  localparam logic [7:0] CMD_LOCKDN   = 8'h2F;  // Lock-down block.
  localparam logic [7:0] CMD_RCR_SET  = 8'h03;  // Load read configuration register.
  localparam logic [7:0] CMD_PGM_W    = 8'h40;  // Word program.
  localparam logic [7:0] CMD_PGM_B    = 8'hE8;  // Buffered program.

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam logic [7:0]  STATUS_RST  = 8'h80;   // Ready only.
  localparam logic [15:0] RCR_RST     = 16'hF800; // Async reads, longest latency code.
  localparam int          ERASE_CYC   = 4096;    // Internal erase length in cycles.
  localparam int          BLANK_CYC   = 1024;    // Block scan length in cycles.
  localparam int          STOP_LOG2   = 4;       // Stopping point every 16 cycles.
  localparam int          CNT_W       = 13;      // Width of the operation counter.
  localparam logic [15:0] ID_PAD      = 16'h0000; // Upper bits of a lock bit read.

  // ****************************************************************
  // Types
  // ****************************************************************
  // Status word, bit 7 down to bit 0.
  typedef struct packed {
    logic rdy;     // device_ready_bit
    logic esusp;   // erase_suspended_bit
    logic efail;   // erase_fail_bit
    logic pfail;   // program_fail_bit
    logic vpp;     // supply_error_bit
    logic psusp;   // program suspended
    logic labort;  // lock_abort_bit
    logic bbusy;   // buffer_busy_bit
  } ebl_status_s;

  // Command write carrier.
  typedef struct packed {
    logic [7:0]  code;  // Command byte.
    logic [15:0] cfg;   // Configuration word for the read configuration load.
  } ebl_cmd_s;

  // Per-block lock state: lockdown_bit_line and lock_bit_line order.
  typedef struct packed {
    logic ldn;
    logic lck;
  } ebl_lk_s;

  typedef enum logic [2:0] {ST_IDLE, ST_ECHK, ST_ERASE, ST_ESUSP, ST_BLANK} ebl_state_e;
  typedef enum logic [1:0] {SU_NONE, SU_ERASE, SU_BLANK, SU_LOCK} ebl_setup_e;
  typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_IDENT} ebl_rmode_e;

endpackage : ebl_pkg

// *** dv/ebl_pgm_model.sv ***
// Program engine model that answers the erase and lock control.
module ebl_pgm_model
  import ebl_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  req_i,       // Program request pulse.
  input  wire logic  susp_req_i,  // Program suspend pulse.
  output logic       busy_o,
  output logic       susp_o,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;  // Program cycles left.
  // A program runs fifteen cycles; a suspend freezes it, since the engine must not move then.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r  <= 4'h0;
      susp_o <= 1'b0;
      data_o <= 16'hA5C3;
    end else begin
      data_o <= ~data_o;  // The array word inverts every cycle, so data one cycle stale never matches.
      if (req_i) begin
        cnt_r  <= 4'hF;
        susp_o <= 1'b0;
      end else if (susp_req_i && busy_o) begin
        susp_o <= 1'b1;
      end else if (!susp_o && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
  assign busy_o = (cnt_r != 4'h0) && !susp_o;
endmodule : ebl_pgm_model

// *** dv/tb_top.sv ***
// Testbench for the erase and block lock control.
module tb_top
  import ebl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, we, ce_n, wp_n, vpp_low, vfail, pbusy, psusp, preq, psreq, stby, ers_o;
  ebl_cmd_s    cmd_d;
  logic [3:0]  cblk, rblk;
  logic [15:0] adata, rdata, read_configuration_register;
  logic [7:0]  stat;
  int          num_errors = 0;
  int          checks     = 0;

  ebl_ctrl #(.ERASE_CYCLES(64), .BLANK_CYCLES(32)) i_ebl_ctrl (.REF_CLK_I(clk), .RST_I(rst),
    .CMD_WE_I(we), .CMD_I(cmd_d), .CMD_BLK_I(cblk), .RD_BLK_I(rblk), .ARRAY_DATA_I(adata),
    .CE_N_I(ce_n), .WP_N_I(wp_n), .VPP_LOW_I(vpp_low), .VERIFY_FAIL_I(vfail),
    .PGM_BUSY_I(pbusy), .PGM_SUSP_I(psusp), .RD_DATA_O(rdata), .STATUS_O(stat), .RCR_O(read_configuration_register),
    .STANDBY_O(stby), .ERASING_O(ers_o), .PGM_REQ_O(preq), .PGM_SUSP_REQ_O(psreq));
  ebl_pgm_model i_ebl_pgm_model (.clk_i(clk), .rst_i(rst), .req_i(preq), .susp_req_i(psreq),
    .busy_o(pbusy), .susp_o(psusp), .data_o(adata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out();
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cs(input logic [7:0] e);
    chk({8'h00, stat}, {8'h00, e});
  endtask : cs

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // One write strobe per call; the strobe drops for a cycle between writes.
  task automatic cmd(input logic [7:0] c, input logic [3:0] b);
    @(posedge clk);
    we         <= 1'b1;
    cmd_d.code <= c;
    cblk       <= b;
    @(posedge clk);
    we <= 1'b0;
  endtask : cmd

  task automatic pair(input logic [7:0] a, input logic [7:0] c, input logic [3:0] b);
    cmd(a, b);
    cmd(c, b);
  endtask : pair

  // Busy shows one edge after the confirm, so the poll starts three edges late on purpose.
  task automatic wait_st(input logic [7:0] m, input int n);
    settle(3);
    for (int i = 0; i < n && (stat & m) !== m; i++) settle(1);
  endtask : wait_st

  task automatic idq(input logic [3:0] b, input logic [15:0] e);
    @(posedge clk) rblk <= b;
    cmd(CMD_RD_ID, 4'h0);
    settle(4);
    chk(rdata, e);
  endtask : idq

  initial begin
    rst     <= 1'b1;
    {we, ce_n, vpp_low, vfail, wp_n} <= 5'h01;
    {cblk, rblk} <= 8'h00;
    cmd_d   <= '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    cs(8'h80);
    pair(CMD_ERASE_SU, CMD_CONFIRM, 4'h2);
    wait_st(8'h80, 20);
    cs(8'hA2);
    cmd(CMD_CLR_STAT, 4'h0);
    settle(1);
    cs(8'h80);
    @(posedge clk) vpp_low <= 1'b1;
    pair(CMD_LOCK_SU, CMD_UNLOCK, 4'h2);
    idq(4'h2, 16'h0000);
    @(posedge clk) {vpp_low, ce_n} <= 2'b01;
    pair(CMD_ERASE_SU, CMD_CONFIRM, 4'h2);
    settle(2);
    chk({13'h0, stat[7], ers_o, stby}, 16'h0002);
    cmd(CMD_SUSPEND, 4'h9);
    wait_st(8'hC0, 24);
    cs(8'hC0);
    chk({8'h00, stat & 8'hC0}, 16'h00C0);
    chk({15'h0000, stby}, 16'h0001);
    pair(CMD_LOCK_SU, CMD_LOCK, 4'h2);
    idq(4'h2, 16'h0001);
    cmd(CMD_PGM_W, 4'h2);
    settle(1);
    cs(8'hD0);
    cmd(CMD_CLR_STAT, 4'h0);
    cmd(CMD_PGM_W, 4'h5);
    cmd(CMD_RESUME, 4'h7);
    settle(1);
    chk({8'h00, stat & 8'hC0}, 16'h0000);
    settle(4);
    chk({15'h0000, ers_o}, 16'h0000);
    wait_st(8'h80, 200);
    cs(8'h80);
    settle(1);
    chk(rdata, 16'h0080);
    chk({15'h0000, stby}, 16'h0001);
    @(posedge clk) ce_n <= 1'b0;
    pair(CMD_LOCK_SU, CMD_UNLOCK, 4'h2);
    pair(CMD_BLANK_SU, CMD_CONFIRM, 4'h2);
    cmd(CMD_SUSPEND, 4'h0);
    settle(1);
    cs(8'h00);
    wait_st(8'h80, 100);
    cs(8'h80);
    pair(CMD_BLANK_SU, CMD_CONFIRM, 4'h5);
    wait_st(8'h80, 100);
    cs(8'hA0);
    cmd(CMD_CLR_STAT, 4'h0);
    @(posedge clk) vfail <= 1'b1;
    pair(CMD_ERASE_SU, CMD_CONFIRM, 4'h2);
    wait_st(8'h80, 200);
    cs(8'hA0);
    @(posedge clk) vfail <= 1'b0;
    pair(CMD_CLR_STAT, CMD_ERASE_SU, 4'h2);
    cmd(CMD_CONFIRM, 4'h2);
    settle(3);
    @(posedge clk) vpp_low <= 1'b1;
    wait_st(8'h80, 20);
    cs(8'h88);
    @(posedge clk) vpp_low <= 1'b0;
    pair(CMD_CLR_STAT, CMD_LOCK_SU, 4'h0);
    cmd(CMD_CLR_STAT, 4'h0);
    settle(1);
    cs(8'hB0);
    cmd(CMD_CLR_STAT, 4'h0);
    pair(CMD_LOCK_SU, CMD_LOCKDN, 4'h3);
    @(posedge clk) wp_n <= 1'b0;
    pair(CMD_LOCK_SU, CMD_UNLOCK, 4'h3);
    idq(4'h3, 16'h0003);
    @(posedge clk) wp_n <= 1'b1;
    pair(CMD_LOCK_SU, CMD_UNLOCK, 4'h3);
    idq(4'h3, 16'h0002);
    @(posedge clk) cmd_d.cfg <= 16'h1234;
    pair(CMD_LOCK_SU, CMD_RCR_SET, 4'h0);
    settle(1);
    chk(read_configuration_register, 16'h1234);
    cmd(CMD_PGM_W, 4'h4);
    cmd(CMD_SUSPEND, 4'h0);
    pair(CMD_LOCK_SU, CMD_UNLOCK, 4'h4);
    idq(4'h4, 16'h0001);
    cs(8'h84);
    pair(CMD_ERASE_SU, CMD_CONFIRM, 4'h2);
    settle(3);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk({stat, read_configuration_register[15:8]}, 16'h80F8);
    chk({15'h0000, ers_o}, 16'h0000);
    idq(4'h2, 16'h0001);
    idq(4'h3, 16'h0001);
    close_out();
  end

  // The tests need a few hundred cycles; this limit leaves a wide margin.
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule : tb_top
